// file: rtl/dlc_pkg.sv
package dlc_pkg;
    // ----------------------------------------------------------------
    // control byte layout
    // ----------------------------------------------------------------
    localparam int CTL_BITS = 8;
    localparam int CTL_STEER = 7;
    localparam int CTL_STANDBY = 6;
    localparam int CTL_CUR_HI = 5;
    localparam int CTL_CUR_LO = 4;
    localparam int CTL_DET_TYPE = 2;
    localparam int CTL_PORT = 1;
    localparam int CTL_POL = 0;
    localparam logic [7:0] CTL_RESET = 8'h32;
    localparam logic [3:0] CTL_WRITE_CLOCKS = 4'h8;
    localparam logic [3:0] CNT_SATURATE = 4'h9;
    localparam int NUM_LOOPS = 2;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        LOOP_RUN = 2'b00,
        LOOP_STANDBY = 2'b01,
        LOOP_ARMED = 2'b10
    } dlc_loop_state_t;

    typedef struct packed {
        logic phi_r_n;
        logic phi_v_n;
        logic pump_oe;
        logic pump_level;
        logic lock_oe;
        logic counter_en;
        logic rx_en;
        logic prescaler_en;
        logic jam_load;
        logic [1:0] current_scale;
        logic detector_type_select;
    } dlc_loop_out_t;
endpackage

// file: rtl/dlc_loop.sv
`timescale 1ns/1ns
module dlc_loop (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic [7:0] ctl,
    input wire logic standby,
    input wire logic reference_divided_pulse,
    input wire logic vco_divided_pulse,
    output dlc_pkg::dlc_loop_out_t lo
);
    import dlc_pkg::*;

    dlc_loop_state_t state_reg;
    logic r_pend_reg;
    logic v_pend_reg;
    logic r_any;
    logic v_any;
    logic polarity_select;

    assign r_any = r_pend_reg | reference_divided_pulse;
    assign v_any = v_pend_reg | vco_divided_pulse;
    assign polarity_select = ctl[CTL_POL];

    // ----------------------------------------------------------------
    // standby sequencing
    // ----------------------------------------------------------------
    // power-up goes through the armed step so counters start jam-loaded
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            state_reg <= LOOP_ARMED;
        end else begin
            case (state_reg)
                LOOP_RUN: if (standby) state_reg <= LOOP_STANDBY; // R3
                LOOP_STANDBY: if (!standby) state_reg <= LOOP_ARMED; // R10
                LOOP_ARMED: begin
                    if (standby) begin
                        state_reg <= LOOP_STANDBY;
                    end else if (reference_divided_pulse) begin
                        state_reg <= LOOP_RUN; // R11
                    end
                end
                default: state_reg <= LOOP_STANDBY;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // phase/frequency detector
    // ----------------------------------------------------------------
    // both pending means in phase: clear together, no dead zone to hold
    always_ff @(posedge ref_clk) begin
        if (sys_rst || state_reg != LOOP_RUN) begin
            r_pend_reg <= 1'b0; // R10
            v_pend_reg <= 1'b0;
        end else begin
            r_pend_reg <= r_any & ~v_any;
            v_pend_reg <= v_any & ~r_any;
        end
    end

    // ----------------------------------------------------------------
    // loop outputs
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            lo <= '0;
            lo.phi_r_n <= 1'b1;
            lo.phi_v_n <= 1'b1;
            lo.current_scale <= CTL_RESET[CTL_CUR_HI:CTL_CUR_LO];
        end else begin
            // R5 R17 R19
            lo.phi_r_n <= ~(state_reg == LOOP_RUN && (polarity_select ? v_pend_reg : r_pend_reg));
            lo.phi_v_n <= ~(state_reg == LOOP_RUN && (polarity_select ? r_pend_reg : v_pend_reg));
            // R4 R14
            lo.pump_oe <= state_reg == LOOP_RUN && !ctl[CTL_DET_TYPE]
                && (r_pend_reg ^ v_pend_reg);
            lo.pump_level <= r_pend_reg ^ polarity_select; // R17
            // R6 R18
            lo.lock_oe <= state_reg == LOOP_STANDBY
                || (state_reg == LOOP_RUN && (r_pend_reg | v_pend_reg));
            lo.counter_en <= state_reg != LOOP_STANDBY; // R4
            lo.rx_en <= state_reg != LOOP_STANDBY;
            lo.prescaler_en <= state_reg == LOOP_RUN;
            lo.jam_load <= state_reg == LOOP_ARMED && !standby
                && reference_divided_pulse; // R11
            lo.current_scale <= ctl[CTL_CUR_HI:CTL_CUR_LO]; // R12
            lo.detector_type_select <= ctl[CTL_DET_TYPE]; // R14
        end
    end

    property p_standby_rest;
        @(posedge ref_clk) disable iff (sys_rst)
        state_reg == LOOP_STANDBY |=> lo.phi_r_n && lo.phi_v_n && lo.lock_oe
            && !lo.pump_oe && !lo.counter_en && !lo.prescaler_en;
    endproperty
    a_standby_rest: assert property (p_standby_rest) else $error("standby outputs wrong"); // R4 R5 R6

    property p_armed_blocked;
        @(posedge ref_clk) disable iff (sys_rst)
        state_reg == LOOP_ARMED |=> lo.phi_r_n && lo.phi_v_n && lo.counter_en && lo.rx_en;
    endproperty
    a_armed_blocked: assert property (p_armed_blocked) else $error("armed not blocking"); // R10

    property p_jam_then_run;
        @(posedge ref_clk) disable iff (sys_rst)
        state_reg == LOOP_ARMED && !standby && reference_divided_pulse
            |=> lo.jam_load ##1 lo.prescaler_en;
    endproperty
    a_jam_then_run: assert property (p_jam_then_run) else $error("jam load missing"); // R11

    property p_vco_lead;
        @(posedge ref_clk) disable iff (sys_rst)
        state_reg == LOOP_RUN && v_pend_reg && !polarity_select |=> !lo.phi_v_n && lo.phi_r_n;
    endproperty
    a_vco_lead: assert property (p_vco_lead) else $error("vco lead pulse wrong"); // R19

    property p_lock_and;
        @(posedge ref_clk) disable iff (sys_rst)
        state_reg == LOOP_RUN |=> lo.lock_oe == !(lo.phi_r_n && lo.phi_v_n);
    endproperty
    a_lock_and: assert property (p_lock_and) else $error("lock not AND of phases"); // R18
endmodule

// file: rtl/dlc_top.sv
`timescale 1ns/1ns
// Overview of operation
// R1: control bit 7 low steers the byte to main, high to secondary register.
// R2: a control write is exactly 8 serial clocks; only the selected register changes.
// R3: main standby bit stops both loops; secondary standby bit stops only secondary.
// R4: in standby: pump floats, counters stop, Rx current off, prescaler halted.
// R5: in standby both double-ended detector outputs of that loop stay high.
// R6: in standby that loop's lock indicator is driven low.
// R7: standby keeps register contents and serial writes still work.
// R8: static-low reference mode plus main standby opens feedback resistor, gates reference.
// R9: secondary standby leaves reference alone; other reference modes untouched.
// R10: leaving standby re-enables counters and current, detectors still blocked.
// R11: next reference pulse jam-loads counters, starts prescaler, enables detectors.
// R12: current scale bits 00/01/10/11 give 5/50/80/100 percent pump current.
// R13: reset sets both current scale bits high.
// R14: detector type high selects double-ended, low selects source/sink with Rx pin.
// R15: reset clears detector type in both registers.
// R16: port bit of main register drives port output: high releases, low drives low.
// R17: polarity bit inverts pump sense and swaps detector outputs; reset clears it.
// R18: lock indicator is AND of the two active-low detector signals, open drain.
// R19: polarity low and vco leading pulses vco side low, reference side high.
// R20: commit only at enable release after exactly eight serial clocks.
module dlc_top (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic ser_clk,
    input wire logic ser_data,
    input wire logic ser_enable_n,
    input wire logic [1:0] reference_divided_pulse,
    input wire logic [1:0] vco_divided_pulse,
    input wire logic ref_static_low_sel,
    input wire logic port_mode_sel,
    output dlc_pkg::dlc_loop_out_t [1:0] loop_out,
    output logic ref_feedback_connect,
    output logic reference_input_gate,
    output logic port_out_oe
);
    import dlc_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [2:0] sclk_sync_reg;
    logic [2:0] en_sync_reg;
    logic [1:0] data_sync_reg;
    logic sclk_rise;
    logic en_fall;
    logic en_rise;
    logic en_active;

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sclk_sync_reg <= 3'h0;
            en_sync_reg <= 3'h7;
            data_sync_reg <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], ser_clk};
            en_sync_reg <= {en_sync_reg[1:0], ser_enable_n};
            data_sync_reg <= {data_sync_reg[0], ser_data};
        end
    end

    // the edge logic reads only the second and third stages
    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign en_fall = ~en_sync_reg[1] & en_sync_reg[2];
    assign en_rise = en_sync_reg[1] & ~en_sync_reg[2];
    assign en_active = ~en_sync_reg[1];

    // ----------------------------------------------------------------
    // serial shifter
    // ----------------------------------------------------------------
    logic [7:0] shift_reg;
    logic [3:0] count_reg;
    logic commit;

    // data sync is one stage shorter than clock sync so data has the same delay as the newer edge sample
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            shift_reg <= 8'h00;
        end else if (en_active && sclk_rise) begin
            shift_reg <= {shift_reg[6:0], data_sync_reg[1]};
        end
    end

    // longer frames saturate the count and are never taken as control writes
    always_ff @(posedge ref_clk) begin
        if (sys_rst || en_fall) begin
            count_reg <= 4'h0;
        end else if (en_active && sclk_rise && count_reg != CNT_SATURATE) begin
            count_reg <= count_reg + 4'h1;
        end
    end

    assign commit = en_rise && count_reg == CTL_WRITE_CLOCKS; // R2 R20

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [7:0] main_ctl_reg;
    logic [7:0] sec_ctl_reg;

    // R13 R15 R17 reset values; standby never touches these
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            main_ctl_reg <= CTL_RESET;
        end else if (commit && !shift_reg[CTL_STEER]) begin
            main_ctl_reg <= shift_reg; // R1 R7
        end
    end

    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            sec_ctl_reg <= CTL_RESET;
        end else if (commit && shift_reg[CTL_STEER]) begin
            sec_ctl_reg <= shift_reg; // R1 R7
        end
    end

    // ----------------------------------------------------------------
    // loops
    // ----------------------------------------------------------------
    logic [1:0] loop_standby;
    logic [1:0][7:0] loop_ctl;

    assign loop_standby[0] = main_ctl_reg[CTL_STANDBY]; // R3
    assign loop_standby[1] = main_ctl_reg[CTL_STANDBY] | sec_ctl_reg[CTL_STANDBY];
    assign loop_ctl[0] = main_ctl_reg;
    assign loop_ctl[1] = sec_ctl_reg;

    genvar g;
    generate
        for (g = 0; g < NUM_LOOPS; g++) begin : g_loop
            dlc_loop u_loop (
                .ref_clk(ref_clk),
                .sys_rst(sys_rst),
                .ctl(loop_ctl[g]),
                .standby(loop_standby[g]),
                .reference_divided_pulse(reference_divided_pulse[g]),
                .vco_divided_pulse(vco_divided_pulse[g]),
                .lo(loop_out[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // reference gating and port output
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            ref_feedback_connect <= 1'b1;
            reference_input_gate <= 1'b1;
        end else begin
            // only main standby counts here; secondary standby leaves reference alone
            ref_feedback_connect <= !(ref_static_low_sel && main_ctl_reg[CTL_STANDBY]); // R8 R9
            reference_input_gate <= !(ref_static_low_sel && main_ctl_reg[CTL_STANDBY]);
        end
    end

    // open drain: high bit releases, low bit pulls low; secondary copy unused
    always_ff @(posedge ref_clk) begin
        if (sys_rst) begin
            port_out_oe <= 1'b0;
        end else begin
            port_out_oe <= port_mode_sel && !main_ctl_reg[CTL_PORT]; // R16
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_commit_main;
        @(posedge ref_clk) disable iff (sys_rst)
        commit && !shift_reg[CTL_STEER] |=> main_ctl_reg == $past(shift_reg)
            && $stable(sec_ctl_reg);
    endproperty
    a_commit_main: assert property (p_commit_main) else $error("main write wrong"); // R1 R2

    property p_commit_sec;
        @(posedge ref_clk) disable iff (sys_rst)
        commit && shift_reg[CTL_STEER] |=> sec_ctl_reg == $past(shift_reg)
            && $stable(main_ctl_reg);
    endproperty
    a_commit_sec: assert property (p_commit_sec) else $error("secondary write wrong"); // R1 R2

    property p_bad_count;
        @(posedge ref_clk) disable iff (sys_rst)
        en_rise && count_reg != CTL_WRITE_CLOCKS |=> $stable(main_ctl_reg)
            && $stable(sec_ctl_reg);
    endproperty
    a_bad_count: assert property (p_bad_count) else $error("non-8 frame committed"); // R20

    property p_main_standby;
        @(posedge ref_clk) disable iff (sys_rst)
        main_ctl_reg[CTL_STANDBY] [*3] |-> !loop_out[0].counter_en && !loop_out[1].counter_en;
    endproperty
    a_main_standby: assert property (p_main_standby) else $error("main standby ignored"); // R3

    property p_sec_standby;
        @(posedge ref_clk) disable iff (sys_rst)
        sec_ctl_reg[CTL_STANDBY] [*3] |-> !loop_out[1].counter_en && loop_out[1].lock_oe;
    endproperty
    a_sec_standby: assert property (p_sec_standby) else $error("secondary standby ignored"); // R3

    property p_ref_gate;
        @(posedge ref_clk) disable iff (sys_rst)
        ref_static_low_sel && main_ctl_reg[CTL_STANDBY] |=> !reference_input_gate
            && !ref_feedback_connect;
    endproperty
    a_ref_gate: assert property (p_ref_gate) else $error("reference not gated"); // R8

    property p_ref_kept;
        @(posedge ref_clk) disable iff (sys_rst)
        !main_ctl_reg[CTL_STANDBY] |=> reference_input_gate && ref_feedback_connect;
    endproperty
    a_ref_kept: assert property (p_ref_kept) else $error("reference gated wrongly"); // R9

    property p_port;
        @(posedge ref_clk) disable iff (sys_rst)
        port_mode_sel ##1 port_mode_sel |-> port_out_oe == !$past(main_ctl_reg[CTL_PORT]);
    endproperty
    a_port: assert property (p_port) else $error("port output wrong"); // R16

    property p_reset_values;
        @(posedge ref_clk)
        $fell(sys_rst) |-> main_ctl_reg[CTL_CUR_HI:CTL_CUR_LO] == 2'h3
            && !main_ctl_reg[CTL_DET_TYPE] && !sec_ctl_reg[CTL_DET_TYPE]
            && !main_ctl_reg[CTL_POL] && !sec_ctl_reg[CTL_POL];
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong"); // R13 R15 R17
endmodule

// file: dv/dlc_host.sv
`timescale 1ns/1ns
module dlc_host (
    output logic ser_clk,
    output logic ser_data,
    output logic ser_enable_n
);
    // ------------------------------------------------------------
    // serial master; clock idles low between frames
    // ------------------------------------------------------------
    initial begin
        ser_clk = 1'b0;
        ser_data = 1'b0;
        ser_enable_n = 1'b1;
    end

    // nbits other than 8 builds a frame that the block must drop
    task automatic send(input logic [7:0] val, input int nbits);
        logic [7:0] sh;
        sh = val;
        ser_enable_n = 1'b0;
        #60;
        for (int i = 0; i < nbits; i++) begin
            ser_data = sh[7];
            sh = {sh[6:0], ~sh[0]};
            #62 ser_clk = 1'b1;
            #63 ser_clk = 1'b0;
        end
        #60 ser_enable_n = 1'b1;
        // released data line must not keep its last level
        ser_data = ~ser_data;
        #100;
    endtask
endmodule

// file: dv/tb_dual_loop_control_register.sv
`timescale 1ns/1ns
module tb_dual_loop_control_register;
    import dlc_pkg::*;
    logic ref_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic ser_clk;
    logic ser_data;
    logic ser_enable_n;
    logic [1:0] rpulse = 2'b00;
    logic [1:0] vpulse = 2'b00;
    logic static_low = 1'b0;
    logic port_mode = 1'b1;
    dlc_loop_out_t [1:0] lo;
    logic fb_conn;
    logic ref_gate;
    logic port_oe;
    int mismatches = 0;
    int n_tests = 0;
    int cycles = 0;
    int k;

    always #5 ref_clk = ~ref_clk;

    dlc_host host (
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_enable_n(ser_enable_n)
    );

    dlc_top DUT (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .ser_clk(ser_clk),
        .ser_data(ser_data),
        .ser_enable_n(ser_enable_n),
        .reference_divided_pulse(rpulse),
        .vco_divided_pulse(vpulse),
        .ref_static_low_sel(static_low),
        .port_mode_sel(port_mode),
        .loop_out(lo),
        .ref_feedback_connect(fb_conn),
        .reference_input_gate(ref_gate),
        .port_out_oe(port_oe)
    );

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic stop_test();
        $display("mismatches %0d n_tests %0d", mismatches, n_tests);
        if (mismatches == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] val);
        host.send(val, 8);
        repeat (10) @(negedge ref_clk);
    endtask

    // one-cycle pulse on the chosen loop, driven at the falling edge
    task automatic pulse(input bit vco, input int idx);
        @(negedge ref_clk);
        if (vco) vpulse[idx] = 1'b1;
        else rpulse[idx] = 1'b1;
        @(negedge ref_clk);
        vpulse = 2'b00;
        rpulse = 2'b00;
    endtask

    // checks pump/lock/detector fields of a loop held in standby
    task automatic chk_standby(input int idx);
        chk({lo[idx].pump_oe, lo[idx].counter_en, lo[idx].rx_en, lo[idx].prescaler_en}, 0);
        chk({lo[idx].phi_r_n, lo[idx].phi_v_n}, 2'b11);
        chk(lo[idx].lock_oe, 1'b1);
    endtask

    // vco leads on the main loop: one output pulses, lock pin pulls low
    task automatic lead(input logic [1:0] exp_rv);
        pulse(1'b1, 0);
        @(negedge ref_clk);
        chk({lo[0].phi_r_n, lo[0].phi_v_n}, exp_rv);
        chk(lo[0].lock_oe, 1'b1);
        pulse(1'b0, 0);
        repeat (3) @(negedge ref_clk);
        chk({lo[0].phi_r_n, lo[0].phi_v_n, lo[0].lock_oe}, 3'b110);
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            stop_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (3) @(negedge ref_clk);
        sys_rst = 1'b0;
        chk({lo[0].current_scale, lo[1].current_scale}, 4'hF);
        chk({lo[0].detector_type_select, lo[1].detector_type_select}, 0);
        chk({lo[0].phi_r_n, lo[0].phi_v_n, lo[1].phi_r_n, lo[1].phi_v_n}, 4'hF);
        chk({fb_conn, ref_gate, port_oe}, 3'b110);
        pulse(1'b0, 0);
        pulse(1'b0, 1);
        for (int s = 0; s < 4; s++) begin
            wr({2'b00, s[1:0], 4'h6});
            chk({lo[0].current_scale, lo[0].detector_type_select}, {s[1:0], 1'b1});
            chk({lo[1].current_scale, lo[1].detector_type_select}, 3'b110);
        end
        wr(8'hA4);
        chk({lo[1].current_scale, lo[1].detector_type_select}, 3'b101);
        chk(lo[0].current_scale, 2'b11);
        chk(port_oe, 1'b0);
        host.send(8'h04, 7);
        host.send(8'h04, 9);
        repeat (10) @(negedge ref_clk);
        chk(lo[0].current_scale, 2'b11);
        wr(8'h34);
        chk(port_oe, 1'b1);
        lead(2'b10);
        wr(8'h35);
        lead(2'b01);
        // source/sink detector: pump drives only while one side is pending
        wr(8'h30);
        pulse(1'b1, 0);
        @(negedge ref_clk);
        chk({lo[0].pump_oe, lo[0].pump_level}, 2'b10);
        pulse(1'b0, 0);
        wr(8'h31);
        chk(lo[0].pump_oe, 1'b0);
        pulse(1'b1, 0);
        @(negedge ref_clk);
        chk({lo[0].pump_oe, lo[0].pump_level}, 2'b11);
        pulse(1'b0, 0);
        wr(8'h34);
        wr(8'hE4);
        chk_standby(1);
        chk(lo[0].counter_en, 1'b1);
        chk({fb_conn, ref_gate}, 2'b11);
        pulse(1'b1, 1);
        @(negedge ref_clk);
        chk({lo[1].phi_r_n, lo[1].phi_v_n}, 2'b11);
        static_low = 1'b1;
        wr(8'h74);
        chk_standby(0);
        chk({fb_conn, ref_gate, port_oe}, 3'b001);
        wr(8'h44);
        chk(lo[0].current_scale, 2'b00);
        wr(8'h04);
        wr(8'hA4);
        chk({lo[0].counter_en, lo[0].rx_en, lo[0].prescaler_en}, 3'b110);
        chk({fb_conn, ref_gate}, 2'b11);
        pulse(1'b1, 0);
        @(negedge ref_clk);
        chk({lo[0].phi_v_n, lo[0].lock_oe}, 2'b10);
        pulse(1'b0, 0);
        k = 0;
        while (lo[0].jam_load !== 1'b1 && k < 4) begin
            @(negedge ref_clk);
            k++;
        end
        chk(lo[0].jam_load, 1'b1);
        repeat (2) @(negedge ref_clk);
        chk({lo[0].prescaler_en, lo[0].jam_load}, 2'b10);
        stop_test();
    end
endmodule
